// ### rtl/dtc_consts.svh
/*
 holds: offsets, field positions and reset values of the dma
 channel time-out control block.
 assumes: included by bare name from the design files.
*/
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH
// ****************************************
// register byte offsets
// ****************************************
`define DTC_OFF_SER_STAT0 8'h00
`define DTC_OFF_SER_DEF0  8'h04
`define DTC_OFF_SER_STAT1 8'h08
`define DTC_OFF_SER_DEF1  8'h0c
`define DTC_OFF_PAR_DEF   8'h10
`define DTC_OFF_PAR_STAT  8'h14
`define DTC_OFF_IRQ_STAT  8'h18
`define DTC_OFF_IRQ_CLR   8'h1c
`define DTC_OFF_IRQ_EN    8'h20
// ****************************************
// field positions
// ****************************************
`define DTC_B_FLAG   1
`define DTC_B_LIM_LO 2
`define DTC_B_TEN    7
`define DTC_B_EDB_LO 0
`define DTC_B_OTGL   3
`define DTC_B_ITGL   4
`define DTC_B_CONT   5
`define DTC_B_IEN    6
`define DTC_B_RUN    7
`define DTC_B_TGLWR  4
// ****************************************
// widths and reset values
// ****************************************
`define DTC_IRQ_W    5
`define DTC_RST_LIM  5'h00
`define DTC_RST_IRQ  5'h00
`endif

// ### rtl/dtc_pkg.sv
/*
 holds: types shared by the dma channel time-out control block.
 assumes: nothing beyond a sv compiler.
*/
package dtc_pkg;
    // counter phase of a serial receive channel
    typedef enum logic {TMO_WAIT, TMO_COUNT} dtc_tmo_e;
    // parallel channel definition as seen by the dma engine
    typedef struct packed {
        logic       run;
        logic       done_irq_enable;
        logic       cont;
        logic       in_tgl;
        logic       out_tgl;
        logic [2:0] edb;
    } dtc_par_cfg_s;
endpackage

// ### rtl/dtc_top.sv
/*
 holds: apb register slave, serial receive time-out counters,
 parallel channel definition and interrupt status logic.
 assumes: one clock; sof, byte, error and end strobes are
 one-cycle pulses from logic on the same clock.
*/
// Chosen here: the APB interface to the registers and the placing of the registers.
// Overview of operation
// - flag set only on time-out
// - write one clears flag, zero ignored
// - irq enable low keeps run on time-out
// - five bit limit in 1 ms steps
// - each received byte reloads the counter
// - each sof pulse decrements the counter
// - reaching zero sets flag, halts channel if irq enable set
// - count needs enable, run, first byte
// - counter enable bit seven gates time-out
// - serial error ends with flag zero
// - bits two to zero pick descriptor set
// - toggle zero means x, one y
// - toggles change only via status bit four
// - run falling with irq enable interrupts
// - firmware sets run, device clears it
// - direction comes from port mode register
`timescale 1ns/1ps
`default_nettype none
`include "dtc_consts.svh"
module dtc_top
#(
    parameter int NUM_SER = 2,
    parameter int LIM_W   = 5
)
(
    input  wire logic               CLK,
    input  wire logic               SRST,
    input  wire logic               PSEL,
    input  wire logic               PENABLE,
    input  wire logic               PWRITE,
    input  wire logic [7:0]         PADDR,
    input  wire logic [31:0]        PWDATA,
    output var  logic [31:0]        PRDATA,
    output var  logic               PREADY,
    output var  logic               PSLVERR,
    input  wire logic               SOF_PULSE,
    input  wire logic [1:0]         RX_BYTE,
    input  wire logic [1:0]         RX_ERR,
    input  wire logic               PP_DIR_IN,
    input  wire logic               PAR_END,
    output var  logic [1:0]         SER_RUN,
    output var  dtc_pkg::dtc_par_cfg_s PAR_CFG,
    output var  logic               IRQ
);
    import dtc_pkg::*;

    // ****************************************
    // elaboration checks
    // ****************************************
    if (NUM_SER != 2)
    begin : g_bad_ser
        $error("NUM_SER must be 2");
    end
    if (LIM_W != 5)
    begin : g_bad_lim
        $error("LIM_W must be 5");
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);

    // ****************************************
    // apb handshake
    // ****************************************
    logic             rdy_q;       // high in the access cycle
    logic             err_q;       // unmapped address answer
    logic [31:0]      rdata_q;     // read data, loaded at setup
    wire logic        setup  = PSEL & ~PENABLE & ~rdy_q;
    wire logic        acc    = PSEL & PENABLE & rdy_q;
    wire logic        wr     = acc & PWRITE;
    wire logic [7:0]  wd     = PWDATA[7:0];

    // ****************************************
    // address decode
    // ****************************************
    wire logic hit_st0 = PADDR == `DTC_OFF_SER_STAT0;
    wire logic hit_df0 = PADDR == `DTC_OFF_SER_DEF0;
    wire logic hit_st1 = PADDR == `DTC_OFF_SER_STAT1;
    wire logic hit_df1 = PADDR == `DTC_OFF_SER_DEF1;
    wire logic hit_pdf = PADDR == `DTC_OFF_PAR_DEF;
    wire logic hit_pst = PADDR == `DTC_OFF_PAR_STAT;
    wire logic hit_ist = PADDR == `DTC_OFF_IRQ_STAT;
    wire logic hit_icl = PADDR == `DTC_OFF_IRQ_CLR;
    wire logic hit_ien = PADDR == `DTC_OFF_IRQ_EN;
    wire logic hit_any = hit_st0 | hit_df0 | hit_st1 | hit_df1
                       | hit_pdf | hit_pst | hit_ist | hit_icl
                       | hit_ien;
    wire logic [1:0] wr_st = {wr & hit_st1, wr & hit_st0};
    wire logic [1:0] wr_df = {wr & hit_df1, wr & hit_df0};
    wire logic wr_pdf = wr & hit_pdf;
    wire logic wr_pst = wr & hit_pst;
    wire logic wr_icl = wr & hit_icl;
    wire logic wr_ien = wr & hit_ien;

    // ****************************************
    // serial channel state
    // ****************************************
    logic [LIM_W-1:0] lim_q  [2];  // time-out limit in ms
    logic [LIM_W-1:0] cnt_q  [2];  // down counter
    logic             ten_q  [2];  // counter enable
    logic             flag_q [2];  // time-out flag
    logic             ien_q  [2];  // completion irq enable
    logic             run_q  [2];  // channel run bit
    logic             runp_q [2];  // run one cycle ago
    dtc_tmo_e         ph_q   [2];  // counter phase
    wire logic [1:0]  expire;      // counter reached zero
    wire logic [1:0]  sfall;       // run fell this cycle
    wire logic [7:0]  st_rd  [2];  // status read image
    wire logic [7:0]  df_rd  [2];  // definition read image

    for (genvar g = 0; g < 2; g++)
    begin : g_ser
        // counting needs enable, run and a first byte
        wire logic cnt_on = ten_q[g] & run_q[g]
                          & (ph_q[g] == TMO_COUNT);
        // last step to zero on a sof pulse
        wire logic exp_w = cnt_on & SOF_PULSE & ~RX_BYTE[g]
                         & (cnt_q[g] == LIM_W'(1));
        // hardware clears run on error or enabled time-out
        wire logic kill = RX_ERR[g] | (exp_w & ien_q[g]);
        assign expire[g] = exp_w;
        assign sfall[g]  = runp_q[g] & ~run_q[g];
        assign st_rd[g]  = {ten_q[g], lim_q[g], flag_q[g], 1'b0};
        assign df_rd[g]  = {run_q[g], ien_q[g], 6'h00};

        // status register fields
        always_ff @(posedge CLK)
        begin
            if (SRST)
            begin
                lim_q[g] <= `DTC_RST_LIM;
                ten_q[g] <= 1'b0;
            end
            else if (wr_st[g])
            begin
                // limit in 1 ms steps
                lim_q[g] <= wd[`DTC_B_LIM_LO +: LIM_W];
                ten_q[g] <= wd[`DTC_B_TEN];
            end
        end

        // time-out flag, set wins over clear
        always_ff @(posedge CLK)
        begin
            if (SRST)
                flag_q[g] <= 1'b0;
            else if (exp_w)
                flag_q[g] <= 1'b1;
            else if (wr_st[g] & wd[`DTC_B_FLAG])
                flag_q[g] <= 1'b0;
        end

        // definition register: irq enable and run
        always_ff @(posedge CLK)
        begin
            if (SRST)
            begin
                ien_q[g]  <= 1'b0;
                run_q[g]  <= 1'b0;
                runp_q[g] <= 1'b0;
            end
            else
            begin
                runp_q[g] <= run_q[g];
                if (wr_df[g])
                    ien_q[g] <= wd[`DTC_B_IEN];
                if (kill)
                    run_q[g] <= 1'b0;
                else if (wr_df[g])
                    run_q[g] <= wd[`DTC_B_RUN];
            end
        end

        // down counter and phase, one per channel
        always_ff @(posedge CLK)
        begin
            if (SRST)
            begin
                cnt_q[g] <= `DTC_RST_LIM;
                ph_q[g]  <= TMO_WAIT;
            end
            else if (!run_q[g] || exp_w)
            begin
                // wait again for a first byte
                ph_q[g] <= TMO_WAIT;
            end
            else if (RX_BYTE[g])
            begin
                cnt_q[g] <= lim_q[g];
                ph_q[g]  <= TMO_COUNT;
            end
            else if (cnt_on && SOF_PULSE)
                cnt_q[g] <= cnt_q[g] - LIM_W'(1);
        end

        // byte reloads the limit
        AST_RELOAD: assert property (
            RX_BYTE[g] & run_q[g] & ~expire[g]
            |=> cnt_q[g] == $past(lim_q[g]))
            else $error("counter not reloaded by byte");
        // sof decrements by one
        AST_DEC: assert property (
            SOF_PULSE & ten_q[g] & run_q[g] & ~RX_BYTE[g]
            & ph_q[g] == TMO_COUNT & cnt_q[g] > LIM_W'(1)
            |=> cnt_q[g] == $past(cnt_q[g]) - LIM_W'(1))
            else $error("counter did not step down by one");
        // zero sets flag
        AST_FLAG_SET: assert property (
            expire[g] |=> flag_q[g])
            else $error("flag not set on time-out");
        // write one clears
        AST_FLAG_W1C: assert property (
            wr_st[g] & wd[`DTC_B_FLAG] & ~expire[g]
            |=> ~flag_q[g])
            else $error("flag not cleared by write one");
        // write zero keeps
        AST_FLAG_KEEP: assert property (
            wr_st[g] & ~wd[`DTC_B_FLAG] & flag_q[g]
            |=> flag_q[g])
            else $error("flag lost on write zero");
        // flag rises only from a time-out
        AST_FLAG_CAUSE: assert property (
            $rose(flag_q[g]) |-> $past(expire[g]))
            else $error("flag set without time-out");
        // irq enable low keeps run
        AST_RUN_STAY: assert property (
            expire[g] & ~ien_q[g] & ~RX_ERR[g] & ~wr_df[g]
            |=> run_q[g])
            else $error("run cleared with irq enable low");
        // enabled time-out halts
        AST_HALT: assert property (
            expire[g] & ien_q[g] |=> ~run_q[g] & flag_q[g])
            else $error("channel not halted on time-out");
        // counter enable low never times out
        AST_TEN_OFF: assert property (
            ~ten_q[g] & run_q[g] & ~RX_ERR[g] & ~wr_df[g]
            |=> run_q[g] & ~$rose(flag_q[g]))
            else $error("time-out with counter disabled");
        // serial error ends run with flag kept low
        AST_ERR_NOFLAG: assert property (
            RX_ERR[g] & ~flag_q[g] & ~expire[g]
            |=> ~run_q[g] & ~flag_q[g])
            else $error("serial error reported as time-out");
        // no count before the first byte
        AST_FIRST_BYTE: assert property (
            $rose(run_q[g]) & ~RX_BYTE[g] ##1 (~RX_BYTE[g])[*2]
            |-> ~expire[g])
            else $error("counted before first byte");
    end

    // ****************************************
    // parallel channel definition
    // ****************************************
    dtc_par_cfg_s par_q;           // definition register
    logic         prunp_q;         // run one cycle ago
    wire logic    pfall = prunp_q & ~par_q.run;

    // definition fields; direction comes from PP_DIR_IN
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            par_q   <= '0;
            prunp_q <= 1'b0;
        end
        else
        begin
            prunp_q <= par_q.run;
            if (wr_pdf)
            begin
                par_q.edb  <= wd[`DTC_B_EDB_LO +: 3];
                par_q.cont <= wd[`DTC_B_CONT];
                par_q.done_irq_enable  <= wd[`DTC_B_IEN];
            end
            // toggles follow status bit four only
            if (wr_pst && PP_DIR_IN)
                par_q.in_tgl <= wd[`DTC_B_TGLWR];
            if (wr_pst && !PP_DIR_IN)
                par_q.out_tgl <= wd[`DTC_B_TGLWR];
            // end of transfer clears run
            if (PAR_END)
                par_q.run <= 1'b0;
            else if (wr_pdf)
                par_q.run <= wd[`DTC_B_RUN];
        end
    end

    // toggles move only on a status write
    AST_TGL: assert property (
        $changed(par_q.in_tgl) | $changed(par_q.out_tgl)
        |-> $past(wr_pst))
        else $error("toggle changed without status write");
    // end of transfer clears run
    AST_PAR_END: assert property (
        PAR_END |=> ~par_q.run)
        else $error("parallel run not cleared at end");

    // ****************************************
    // interrupt status, clear and enable
    // ****************************************
    logic [`DTC_IRQ_W-1:0] ist_q;  // sticky status
    logic [`DTC_IRQ_W-1:0] ien_m_q;// enable mask
    logic                  irq_q;  // interrupt output
    // bits: 0,1 time-out; 2,3 serial run fall; 4 parallel run fall
    wire logic [`DTC_IRQ_W-1:0] iev = {
        pfall & par_q.done_irq_enable,
        sfall[1] & ien_q[1],
        sfall[0] & ien_q[0],
        expire[1] & ien_q[1],
        expire[0] & ien_q[0]};
    wire logic [`DTC_IRQ_W-1:0] icl     = wr_icl ? wd[`DTC_IRQ_W-1:0] : '0;
    wire logic [`DTC_IRQ_W-1:0] ist_d   = (ist_q & ~icl) | iev;
    wire logic [`DTC_IRQ_W-1:0] ien_m_d = wr_ien ? wd[`DTC_IRQ_W-1:0] : ien_m_q;

    // set wins over the write-one clear
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            ist_q   <= `DTC_RST_IRQ;
            ien_m_q <= `DTC_RST_IRQ;
            irq_q   <= 1'b0;
        end
        else
        begin
            ist_q   <= ist_d;
            ien_m_q <= ien_m_d;
            irq_q   <= |(ist_d & ien_m_d);
        end
    end

    // run falling with enable reaches status
    AST_PAR_IRQ: assert property (
        pfall & par_q.done_irq_enable |=> ist_q[4])
        else $error("run fall did not raise status");
    // interrupt output tracks enabled status
    AST_IRQ_OUT: assert property (
        ##1 IRQ == |(ist_q & ien_m_q))
        else $error("irq out of step with status");

    // ****************************************
    // read data image
    // ****************************************
    wire logic [7:0] pst_rd = PP_DIR_IN ?
        {3'h0, par_q.in_tgl, 4'h0} : {3'h0, par_q.out_tgl, 4'h0};
    wire logic [7:0] rd8 =
        hit_st0 ? st_rd[0] :
        hit_df0 ? df_rd[0] :
        hit_st1 ? st_rd[1] :
        hit_df1 ? df_rd[1] :
        hit_pdf ? par_q    :
        hit_pst ? pst_rd   :
        hit_ist ? {3'h0, ist_q} :
        hit_ien ? {3'h0, ien_m_q} : 8'h00;

    // apb answer: zero-wait access, data fixed at setup
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            rdy_q   <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            rdy_q <= setup;
            if (setup)
            begin
                err_q   <= ~hit_any;
                rdata_q <= {24'h00_0000, rd8};
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign PRDATA  = rdata_q;
    assign PREADY  = rdy_q;
    assign PSLVERR = err_q;
    assign SER_RUN = {run_q[1], run_q[0]};
    assign PAR_CFG = par_q;
    assign IRQ     = irq_q;
endmodule
`default_nettype wire

// ### bench/dtc_far_end.sv
/*
 holds: far-end model of the receivers, frame tick and parallel port.
 assumes: the bench calls fire() hierarchically, one clock with the dut.
*/
`timescale 1ns/1ps
`default_nettype none
module dtc_far_end
(
    input  wire logic       clk,
    output var  logic       sof_pulse,
    output var  logic [1:0] rx_byte,
    output var  logic [1:0] rx_err,
    output var  logic       par_end
);
    // ****************************************
    // one-cycle strobes, idle low
    // ****************************************
    // strobes rest low between events
    initial
    begin
        sof_pulse = 1'b0;
        rx_byte   = 2'b00;
        rx_err    = 2'b00;
        par_end   = 1'b0;
    end
    // raise the chosen strobes for exactly one cycle
    task automatic fire(input logic s, input logic [1:0] b, input logic [1:0] e,
                        input logic p);
        @(posedge clk);
        sof_pulse <= s;     // frame tick
        rx_byte   <= b;     // byte received
        rx_err    <= e;     // receive error
        par_end   <= p;     // parallel transfer done
        @(posedge clk);
        sof_pulse <= 1'b0;
        rx_byte   <= 2'b00;
        rx_err    <= 2'b00;
        par_end   <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### bench/dma_channel_timeout_control_bench.sv
/*
 holds: self-checking bench for dtc_top, apb tasks and scenarios.
 assumes: dtc_pkg, dtc_consts.svh and dtc_far_end compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dtc_consts.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dma_channel_timeout_control_bench;
    import dtc_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic         clk     = 1'b0;
    logic         srst    = 1'b1;
    logic         psel    = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite  = 1'b0;
    logic         dir_in  = 1'b0;
    logic [7:0]   paddr   = 8'h00;
    logic [31:0]  pwdata  = 32'h0;
    logic [31:0]  prdata;
    logic [31:0]  rd;
    logic         pready;
    logic         pslverr;
    logic         err;
    logic         sof;
    logic         pend;
    logic         irq;
    logic [1:0]   rx_b;
    logic [1:0]   rx_e;
    logic [1:0]   ser_run;
    dtc_par_cfg_s par_cfg;
    int           n_mismatch = 0;
    int           checked    = 0;

    // 200 mhz clock
    always #2.5 clk = ~clk;

    dtc_top u_dut
    (
        .CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SOF_PULSE(sof), .RX_BYTE(rx_b), .RX_ERR(rx_e),
        .PP_DIR_IN(dir_in), .PAR_END(pend), .SER_RUN(ser_run), .PAR_CFG(par_cfg),
        .IRQ(irq)
    );

    dtc_far_end u_far
    (
        .clk(clk), .sof_pulse(sof), .rx_byte(rx_b), .rx_err(rx_e), .par_end(pend)
    );

    // ****************************************
    // tasks
    // ****************************************
    // verdict and end of run
    task automatic wrap_up;
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (pready !== 1'b1 && i < 20);
        if (i >= 20)
        begin
            n_mismatch++;
            wrap_up();
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        // reset values of every readable register
        for (int k = 0; k <= 8; k++)
            if (k != 7)
                rdchk(8'(k * 4), 32'h0);
        rdchk(8'h24, 32'h0);
        `CHK(err, 1'b1)
        `CHK(ser_run, 2'b00)
        `CHK(par_cfg, 8'h00)
        `CHK(irq, 1'b0)
        // channel 0: limit 2, counter on, irq on
        wr(`DTC_OFF_IRQ_EN, 32'h1f);
        wr(`DTC_OFF_SER_STAT0, 32'h88); // nonzero limit with counter on
        wr(`DTC_OFF_SER_DEF0, 32'hc0);
        repeat (3) u_far.fire(1'b1, 2'b00, 2'b00, 1'b0);
        tick(3);
        `CHK(ser_run, 2'b01)
        rdchk(`DTC_OFF_SER_STAT0, 32'h88);
        u_far.fire(1'b0, 2'b01, 2'b00, 1'b0);
        u_far.fire(1'b1, 2'b00, 2'b00, 1'b0);
        u_far.fire(1'b0, 2'b01, 2'b00, 1'b0);
        u_far.fire(1'b1, 2'b00, 2'b00, 1'b0);
        tick(3);
        `CHK(ser_run, 2'b01)
        u_far.fire(1'b1, 2'b00, 2'b00, 1'b0);
        tick(3);
        `CHK(ser_run, 2'b00)
        rdchk(`DTC_OFF_SER_STAT0, 32'h8a);
        rdchk(`DTC_OFF_SER_DEF0, 32'h40);
        rdchk(`DTC_OFF_IRQ_STAT, 32'h05);
        `CHK(irq, 1'b1)
        wr(`DTC_OFF_SER_STAT0, 32'h88);
        rdchk(`DTC_OFF_SER_STAT0, 32'h8a);
        wr(`DTC_OFF_SER_STAT0, 32'h8a);
        rdchk(`DTC_OFF_SER_STAT0, 32'h88);
        wr(`DTC_OFF_IRQ_CLR, 32'h05);
        tick(2);
        `CHK(irq, 1'b0)
        // longest limit, 31 ticks
        wr(`DTC_OFF_SER_STAT0, 32'hfc);
        wr(`DTC_OFF_SER_DEF0, 32'hc0);
        u_far.fire(1'b0, 2'b01, 2'b00, 1'b0);
        repeat (30) u_far.fire(1'b1, 2'b00, 2'b00, 1'b0);
        tick(3);
        `CHK(ser_run, 2'b01)
        u_far.fire(1'b1, 2'b00, 2'b00, 1'b0);
        tick(3);
        `CHK(ser_run, 2'b00)
        rdchk(`DTC_OFF_SER_STAT0, 32'hfe);
        wr(`DTC_OFF_IRQ_CLR, 32'h05);
        // ch0 counter off, ch1 limit 1 with irq enable low
        wr(`DTC_OFF_SER_STAT0, 32'h06);
        wr(`DTC_OFF_SER_DEF0, 32'hc0);
        wr(`DTC_OFF_SER_STAT1, 32'h84);
        wr(`DTC_OFF_SER_DEF1, 32'h80);
        u_far.fire(1'b0, 2'b11, 2'b00, 1'b0);
        repeat (2) u_far.fire(1'b1, 2'b00, 2'b00, 1'b0);
        tick(3);
        `CHK(ser_run, 2'b11)
        rdchk(`DTC_OFF_SER_STAT0, 32'h04);
        rdchk(`DTC_OFF_SER_STAT1, 32'h86);
        rdchk(`DTC_OFF_IRQ_STAT, 32'h00);
        // receive error on ch0, its run-fall irq masked
        wr(`DTC_OFF_IRQ_EN, 32'h1b);
        u_far.fire(1'b0, 2'b00, 2'b01, 1'b0);
        tick(3);
        `CHK(ser_run, 2'b10)
        rdchk(`DTC_OFF_SER_STAT0, 32'h04);
        rdchk(`DTC_OFF_IRQ_STAT, 32'h04);
        `CHK(irq, 1'b0)
        wr(`DTC_OFF_IRQ_EN, 32'h1f);
        tick(2);
        `CHK(irq, 1'b1)
        wr(`DTC_OFF_IRQ_CLR, 32'h04);
        tick(2);
        `CHK(irq, 1'b0)
        // parallel channel: direct toggle writes ignored
        wr(`DTC_OFF_PAR_DEF, 32'hfd); // continuous set
        tick(1);
        `CHK(par_cfg, 8'he5)
        dir_in <= 1'b1;
        wr(`DTC_OFF_PAR_STAT, 32'h10);
        tick(1);
        `CHK(par_cfg, 8'hf5)
        rdchk(`DTC_OFF_PAR_STAT, 32'h10);
        dir_in <= 1'b0;
        wr(`DTC_OFF_PAR_STAT, 32'h10);
        tick(1);
        `CHK(par_cfg, 8'hfd)
        u_far.fire(1'b0, 2'b00, 2'b00, 1'b1);
        tick(3);
        `CHK(par_cfg.run, 1'b0)
        rdchk(`DTC_OFF_IRQ_STAT, 32'h10);
        wr(`DTC_OFF_IRQ_CLR, 32'h10);
        wr(`DTC_OFF_PAR_DEF, 32'ha5); // continuous set
        u_far.fire(1'b0, 2'b00, 2'b00, 1'b1);
        tick(3);
        rdchk(`DTC_OFF_PAR_DEF, 32'h3d);
        rdchk(`DTC_OFF_IRQ_STAT, 32'h00);
        `CHK(irq, 1'b0)
        wrap_up();
    end
endmodule
`default_nettype wire
